// File: isp_pkg.sv
`default_nettype none
package isp_pkg;
	// ============================================================
	// Clock and timing
	localparam int CLOCK_MHZ          = 10;
	localparam int FLASH_PAGE_WAIT_US = 4500;
	localparam int EEPROM_BYTE_WAIT_US = 3600;
	localparam int ERASE_WAIT_US      = 9000;
	localparam int POWER_UP_WAIT_US   = 20000;
	localparam int SCK_MIN_CYCLES     = 3;
	localparam int SCK_HALF_CYCLES    = 8;
	localparam int RESET_PULSE_CYCLES = 4;
	localparam int WAIT_W             = 18;

	// ============================================================
	// Instruction encoding
	localparam logic [7:0] UNLOCK_B1      = 8'hAC;
	localparam logic [7:0] UNLOCK_B2      = 8'h53;
	localparam logic [2:0] ERASE_B2_TOP   = 3'h4;
	localparam logic [7:0] OP_READ_FLASH  = 8'h20;
	localparam logic [7:0] OP_LOAD_PAGE   = 8'h40;
	localparam logic [7:0] OP_WRITE_PAGE  = 8'h4C;
	localparam logic [7:0] OP_READ_EE     = 8'hA0;
	localparam logic [7:0] OP_WRITE_EE    = 8'hC0;
	localparam logic [7:0] HIGH_SEL_MASK  = 8'h08;
	localparam int         HIGH_SEL_BIT   = 3;
	localparam logic [4:0] BYTE3_LAST     = 5'h17;
	localparam logic [4:0] WORD_LAST      = 5'h1F;
	localparam logic [5:0] WORD_BITS      = 6'h20;
	localparam logic [7:0] ERASED_BYTE    = 8'hFF;
	localparam logic [15:0] ERASED_WORD   = 16'hFFFF;

	// ============================================================
	// Array geometry
	localparam int PAGE_WORD_BITS  = 6;
	localparam int FLASH_PAGE_BITS = 2;
	localparam int FLASH_WORD_BITS = PAGE_WORD_BITS + FLASH_PAGE_BITS;
	localparam int PAGE_WORDS      = 1 << PAGE_WORD_BITS;
	localparam int FLASH_WORDS     = 1 << FLASH_WORD_BITS;
	localparam int EE_ADDR_BITS    = 6;
	localparam int EE_BYTES        = 1 << EE_ADDR_BITS;

	// ============================================================
	// States
	typedef enum logic [1:0] {
		ST_OFF    = 2'b00,
		ST_LOCKED = 2'b01,
		ST_OPEN   = 2'b10
	} session_t;

	typedef enum logic [1:0] {
		BUSY_FLASH = 2'b00,
		BUSY_EE    = 2'b01,
		BUSY_ERASE = 2'b10
	} busy_kind_t;

	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_POWER = 3'b001,
		H_SHIFT = 3'b010,
		H_READY = 3'b011,
		H_WAIT  = 3'b100,
		H_PULSE = 3'b101
	} host_state_t;
endpackage
`default_nettype wire

// File: isp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface isp_if;
	logic sck;
	logic mosi;
	logic miso;
	logic reset_n;

	modport device (input sck, input mosi, input reset_n, output miso);
	modport programmer (output sck, output mosi, output reset_n, input miso);
endinterface
`default_nettype wire

// File: isp_device.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Programming accepted only while reset pin low
// - Programmer unlocks before any memory operation
// - EEPROM byte write replaces byte, no erase needed
// - Chip erase fills flash and EEPROM with FF
// - Programmer holds clock low/high over two cycles
// - Incoming bits sampled on serial clock rise
// - Outgoing bits shifted on serial clock fall
// - Power-up keeps reset and clock low
// - Programmer waits 20ms before unlock
// - Second unlock byte echoes during third byte
// - Programmer sends four bytes, resyncs by reset pulse
// - Page buffer loaded per byte at word address
// - Low byte loaded before high byte
// - Page write commits buffer to selected page
// - Programmer waits flash page time without polling
// - EEPROM written per byte, programmer waits
// - Read returns addressed location on output
// - Reset high ends session, normal operation
// - Page being programmed reads FF until done
// - Polling useless for FF, use fixed wait
// - Unlock is AC 53 followed by two bytes
// - Waits: 4.5ms page, 3.6ms EEPROM byte
// - EEPROM byte being written reads FF
module isp_device
	import isp_pkg::*;
#(
	parameter int FLASH_WAIT_CYCLES = FLASH_PAGE_WAIT_US * CLOCK_MHZ,
	parameter int EE_WAIT_CYCLES    = EEPROM_BYTE_WAIT_US * CLOCK_MHZ,
	parameter int ERASE_WAIT_CYCLES = ERASE_WAIT_US * CLOCK_MHZ
) (
	input  wire logic clock,
	input  wire logic rst,
	isp_if.device     link,
	output logic      prog_mode,
	output logic      busy
);

	// ============================================================
	// Helpers
	function automatic logic [FLASH_WORD_BITS-1:0] word_addr(input logic [7:0] hi_b,
		input logic [7:0] lo_b);
		logic [12:0] full;
		full = {hi_b[4:0], lo_b};
		return full[FLASH_WORD_BITS-1:0];
	endfunction

	function automatic logic op_match(input logic [7:0] b, input logic [7:0] op);
		return (b & ~HIGH_SEL_MASK) == op;
	endfunction

	// ============================================================
	// Pin synchronisers
	logic [1:0] sck_s;
	logic [1:0] mosi_s;
	logic [1:0] rstn_s;
	logic       sck_d;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sck_s  <= 2'h0;
			mosi_s <= 2'h0;
			rstn_s <= 2'h3;
			sck_d  <= 1'b0;
		end else begin
			sck_s  <= {sck_s[0], link.sck};
			mosi_s <= {mosi_s[0], link.mosi};
			rstn_s <= {rstn_s[0], link.reset_n};
			sck_d  <= sck_s[1];
		end
	end

	wire logic in_session = ~rstn_s[1];
	wire logic sck_rise   = sck_s[1] & ~sck_d;
	wire logic sck_fall   = ~sck_s[1] & sck_d;

	// ============================================================
	// Storage and state
	session_t         session;
	session_t         next_session;
	logic [4:0]       bit_cnt;
	logic [31:0]      rx;
	logic [7:0]       tx;
	logic [WAIT_W-1:0] busy_cnt;
	busy_kind_t       busy_kind;
	logic [FLASH_PAGE_BITS-1:0] busy_page;
	logic [EE_ADDR_BITS-1:0]    busy_ee;
	logic [15:0]      flash_mem [FLASH_WORDS];
	logic [15:0]      pbuf [PAGE_WORDS];
	logic [7:0]       ee_mem [EE_BYTES];

	// ============================================================
	// Instruction decode
	wire logic [31:0] rx_next   = {rx[30:0], mosi_s[1]};
	wire logic        byte_done = sck_rise && (bit_cnt[2:0] == 3'h7);
	wire logic        word_done = sck_rise && (bit_cnt == WORD_LAST);
	wire logic [7:0]  w1 = rx_next[31:24];
	wire logic [7:0]  w2 = rx_next[23:16];
	wire logic [7:0]  w3 = rx_next[15:8];
	wire logic [7:0]  w4 = rx_next[7:0];
	wire logic [7:0]  q1 = rx_next[23:16];
	wire logic [7:0]  q2 = rx_next[15:8];
	wire logic [7:0]  q3 = rx_next[7:0];
	wire logic is_open   = session == ST_OPEN;
	wire logic do_cmd    = word_done && is_open && !busy;
	wire logic is_unlock = (w1 == UNLOCK_B1) && (w2 == UNLOCK_B2);
	wire logic is_erase  = (w1 == UNLOCK_B1) && (w2[7:5] == ERASE_B2_TOP);
	wire logic do_erase  = do_cmd && is_erase;
	wire logic do_load   = do_cmd && op_match(w1, OP_LOAD_PAGE);
	wire logic do_wpage  = do_cmd && (w1 == OP_WRITE_PAGE);
	wire logic do_wee    = do_cmd && (w1 == OP_WRITE_EE);
	wire logic [FLASH_WORD_BITS-1:0] w_faddr = word_addr(w2, w3);
	wire logic [FLASH_PAGE_BITS-1:0] w_page  = w_faddr[FLASH_WORD_BITS-1:PAGE_WORD_BITS];
	wire logic [PAGE_WORD_BITS-1:0]  w_word  = w3[PAGE_WORD_BITS-1:0];
	wire logic [EE_ADDR_BITS-1:0]    w_eaddr = w3[EE_ADDR_BITS-1:0];

	// ============================================================
	// Read path
	wire logic [FLASH_WORD_BITS-1:0] q_faddr = word_addr(q2, q3);
	wire logic [EE_ADDR_BITS-1:0]    q_eaddr = q3[EE_ADDR_BITS-1:0];
	wire logic [15:0] rd_word  = flash_mem[q_faddr];
	wire logic is_rf   = op_match(q1, OP_READ_FLASH);
	wire logic is_re   = q1 == OP_READ_EE;
	wire logic f_pend  = busy && ((busy_kind == BUSY_ERASE) || ((busy_kind == BUSY_FLASH)
		&& (q_faddr[FLASH_WORD_BITS-1:PAGE_WORD_BITS] == busy_page)));
	wire logic e_pend  = busy && ((busy_kind == BUSY_ERASE) || ((busy_kind == BUSY_EE)
		&& (q_eaddr == busy_ee)));
	wire logic [7:0] f_byte = q1[HIGH_SEL_BIT] ? rd_word[15:8] : rd_word[7:0];
	wire logic [7:0] rd_byte = is_rf ? (f_pend ? ERASED_BYTE : f_byte)
		: (e_pend ? ERASED_BYTE : ee_mem[q_eaddr]);
	wire logic use_rd = (bit_cnt == BYTE3_LAST) && is_open && (is_rf || is_re);
	// Otherwise the byte just received goes back out, giving the unlock echo
	wire logic [7:0] tx_load = use_rd ? rd_byte : rx_next[7:0];

	// ============================================================
	// Session
	assign next_session = !in_session ? ST_OFF
		: (session == ST_OFF) ? ST_LOCKED
		: (word_done && is_unlock) ? ST_OPEN : session;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			session <= ST_OFF;
		end else begin
			session <= next_session;
		end
	end

	// ============================================================
	// Serial shifter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			bit_cnt   <= 5'h0;
			rx        <= 32'h0;
			tx        <= 8'h0;
			link.miso <= 1'b0;
		end else if (!in_session) begin
			bit_cnt   <= 5'h0;
			tx        <= 8'h0;
			link.miso <= 1'b0;
		end else begin
			if (sck_rise) begin
				rx      <= rx_next;
				bit_cnt <= bit_cnt + 5'h1;
			end
			if (byte_done) begin
				tx <= tx_load;
			end else if (sck_fall) begin
				link.miso <= tx[7];
				tx        <= {tx[6:0], 1'b0};
			end
		end
	end

	// ============================================================
	// Self-timed busy
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_cnt  <= '0;
			busy_kind <= BUSY_FLASH;
			busy_page <= '0;
			busy_ee   <= '0;
		end else if (do_erase) begin
			busy_cnt  <= WAIT_W'(ERASE_WAIT_CYCLES);
			busy_kind <= BUSY_ERASE;
		end else if (do_wpage) begin
			busy_cnt  <= WAIT_W'(FLASH_WAIT_CYCLES);
			busy_kind <= BUSY_FLASH;
			busy_page <= w_page;
		end else if (do_wee) begin
			busy_cnt  <= WAIT_W'(EE_WAIT_CYCLES);
			busy_kind <= BUSY_EE;
			busy_ee   <= w_eaddr;
		end else if (busy) begin
			busy_cnt <= busy_cnt - WAIT_W'(1);
		end
	end

	assign busy      = busy_cnt != '0;
	assign prog_mode = is_open;

	// ============================================================
	// Page buffer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				pbuf[i] <= ERASED_WORD;
			end
		end else if (do_load) begin
			if (w1[HIGH_SEL_BIT]) begin
				pbuf[w_word][15:8] <= w4;
			end else begin
				pbuf[w_word][7:0] <= w4;
			end
		end
	end

	// ============================================================
	// Flash array
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < FLASH_WORDS; i++) begin
				flash_mem[i] <= ERASED_WORD;
			end
		end else if (do_erase) begin
			for (int i = 0; i < FLASH_WORDS; i++) begin
				flash_mem[i] <= ERASED_WORD;
			end
		end else if (do_wpage) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				flash_mem[{w_page, PAGE_WORD_BITS'(i)}] <= pbuf[i];
			end
		end
	end

	// ============================================================
	// EEPROM array
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < EE_BYTES; i++) begin
				ee_mem[i] <= ERASED_BYTE;
			end
		end else if (do_erase) begin
			for (int i = 0; i < EE_BYTES; i++) begin
				ee_mem[i] <= ERASED_BYTE;
			end
		end else if (do_wee) begin
			ee_mem[w_eaddr] <= w4;
		end
	end

endmodule
`default_nettype wire

// File: isp_programmer.sv
`timescale 1ns/1ps
`default_nettype none
module isp_programmer
	import isp_pkg::*;
#(
	parameter int POWER_WAIT_CYCLES = POWER_UP_WAIT_US * CLOCK_MHZ,
	parameter int FLASH_WAIT_CYCLES = FLASH_PAGE_WAIT_US * CLOCK_MHZ,
	parameter int EE_WAIT_CYCLES    = EEPROM_BYTE_WAIT_US * CLOCK_MHZ,
	parameter int ERASE_WAIT_CYCLES = ERASE_WAIT_US * CLOCK_MHZ
) (
	input  wire logic        clock,
	input  wire logic        rst,
	isp_if.programmer        link,
	input  wire logic        session_req,
	output logic             session_ok,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [31:0] cmd_word,
	output logic             rsp_valid,
	output logic [7:0]       rsp_data
);

	// ============================================================
	// State
	host_state_t       state;
	logic [1:0]        miso_s;
	logic [WAIT_W-1:0] wait_cnt;
	logic [3:0]        half_cnt;
	logic [5:0]        bits;
	logic [31:0]       tx;
	logic [31:0]       rx;
	logic [31:0]       cur;
	logic              unlocking;

	wire logic tick     = half_cnt == 4'(SCK_HALF_CYCLES - 1);
	wire logic wait_end = wait_cnt == '0;
	wire logic is_wpage = cur[31:24] == OP_WRITE_PAGE;
	wire logic is_wee   = cur[31:24] == OP_WRITE_EE;
	wire logic is_erase = (cur[31:24] == UNLOCK_B1) && (cur[23:21] == ERASE_B2_TOP);
	// Fixed waits stand in for polling, which fails on FF data
	wire logic [WAIT_W-1:0] post_wait = is_erase ? WAIT_W'(ERASE_WAIT_CYCLES)
		: is_wpage ? WAIT_W'(FLASH_WAIT_CYCLES)
		: is_wee ? WAIT_W'(EE_WAIT_CYCLES) : '0;
	wire logic [31:0] unlock_word = {UNLOCK_B1, UNLOCK_B2, 16'h0000};

	assign cmd_ready    = (state == H_READY) && session_req;
	assign link.reset_n = (state == H_IDLE) || (state == H_PULSE);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			miso_s <= 2'h0;
		end else begin
			miso_s <= {miso_s[0], link.miso};
		end
	end

	// ============================================================
	// Sequencer and shifter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state      <= H_IDLE;
			wait_cnt   <= '0;
			half_cnt   <= 4'h0;
			bits       <= 6'h0;
			tx         <= 32'h0;
			rx         <= 32'h0;
			cur        <= 32'h0;
			unlocking  <= 1'b0;
			session_ok <= 1'b0;
			rsp_valid  <= 1'b0;
			rsp_data   <= 8'h0;
			link.sck   <= 1'b0;
			link.mosi  <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			half_cnt  <= tick ? 4'h0 : half_cnt + 4'h1;
			if (!session_req) begin
				state      <= H_IDLE;
				session_ok <= 1'b0;
				link.sck   <= 1'b0;
				link.mosi  <= 1'b0;
			end else begin
				case (state)
				H_IDLE: begin
					state    <= H_POWER;
					wait_cnt <= WAIT_W'(POWER_WAIT_CYCLES);
				end
				H_POWER, H_WAIT, H_PULSE: begin
					if (!wait_end) begin
						wait_cnt <= wait_cnt - WAIT_W'(1);
					end else begin
						// A finished power-up or resync pulse leads to a fresh unlock
						state     <= (state == H_WAIT) ? H_READY : H_SHIFT;
						unlocking <= state != H_WAIT;
						cur       <= unlock_word;
						link.mosi <= unlock_word[31];
						tx        <= {unlock_word[30:0], 1'b0};
						bits      <= 6'h0;
						half_cnt  <= 4'h0;
					end
				end
				H_READY: begin
					if (cmd_valid) begin
						state     <= H_SHIFT;
						unlocking <= 1'b0;
						cur       <= cmd_word;
						link.mosi <= cmd_word[31];
						tx        <= {cmd_word[30:0], 1'b0};
						bits      <= 6'h0;
						half_cnt  <= 4'h0;
					end
				end
				H_SHIFT: begin
					if (tick && !link.sck) begin
						link.sck <= 1'b1;
						rx       <= {rx[30:0], miso_s[1]};
						bits     <= bits + 6'h1;
					end else if (tick) begin
						link.sck <= 1'b0;
						if (bits == WORD_BITS) begin
							if (unlocking && (rx[15:8] != UNLOCK_B2)) begin
								state    <= H_PULSE;
								wait_cnt <= WAIT_W'(RESET_PULSE_CYCLES);
							end else if (unlocking) begin
								state      <= H_READY;
								session_ok <= 1'b1;
							end else begin
								state     <= H_WAIT;
								wait_cnt  <= post_wait;
								rsp_valid <= 1'b1;
								rsp_data  <= rx[7:0];
							end
						end else begin
							link.mosi <= tx[31];
							tx        <= {tx[30:0], 1'b0};
						end
					end
				end
				default: begin
					state <= H_IDLE;
				end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// File: isp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module isp_properties
	import isp_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic reset_n
);
	// ============================================================
	// Bit position within the current instruction word
	logic        sck_d;
	logic [4:0]  nbits;
	logic [31:0] win;
	logic [31:0] wout;
	wire         rise = sck & ~sck_d;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sck_d <= 1'b0;
			nbits <= 5'h00;
			win   <= 32'h0;
			wout  <= 32'h0;
		end else begin
			sck_d <= sck;
			nbits <= reset_n ? 5'h00 : (rise ? nbits + 5'h01 : nbits);
			win   <= rise ? {win[30:0], mosi} : win;
			wout  <= rise ? {wout[30:0], miso} : wout;
		end
	end

	// ============================================================
	// Properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_sck_high_len: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
		else $error("serial clock high time wrong");
	a_sck_low_min: assert property ($fell(sck) |-> !sck[*3])
		else $error("serial clock low time too short");
	a_mosi_low_only: assert property ($changed(mosi) |-> !sck)
		else $error("data in changed while clock high");
	a_miso_on_fall: assert property ($changed(miso) |-> !sck && !$past(sck))
		else $error("data out changed away from clock fall");
	a_miso_quiet_out: assert property (reset_n[*6] |-> !miso)
		else $error("data out active outside session");
	a_entry_sck_low: assert property ($fell(reset_n) |-> !sck && !$past(sck))
		else $error("serial clock high at session entry");
	a_power_wait: assert property ($fell(reset_n) |-> !sck[*8])
		else $error("serial clock started too early");
	a_echo_byte: assert property (
		$changed(nbits) && nbits == 5'h18 && win[23:8] == {UNLOCK_B1, UNLOCK_B2}
		|-> wout[7:0] == UNLOCK_B2)
		else $error("unlock echo missing");
endmodule
`default_nettype wire

// File: serial_isp_programming_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_isp_programming_tb
	import isp_pkg::*;
;
	localparam int SHORT = 40;
	localparam int LONG  = 2000;

	logic        clock;
	logic        rst;
	logic        session_req;
	logic        session_ok;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [31:0] cmd_word;
	logic        rsp_valid;
	logic [7:0]  rsp_data;
	logic        prog_mode;
	logic        busy;
	logic        prog_mode_b;
	logic        busy_b;
	logic [7:0]  expq[$];
	logic [31:0] r;
	logic [7:0]  d;
	logic [7:0]  lo[4];
	logic [7:0]  hi[4];
	integer      seed;
	integer      n_errors;
	integer      n_checks;
	integer      i;

	isp_if link ();
	isp_if link_b ();

	isp_device #(.FLASH_WAIT_CYCLES(SHORT), .EE_WAIT_CYCLES(SHORT), .ERASE_WAIT_CYCLES(SHORT))
		i_isp_device (.clock(clock), .rst(rst), .link(link), .prog_mode(prog_mode), .busy(busy));
	isp_programmer #(.POWER_WAIT_CYCLES(50), .FLASH_WAIT_CYCLES(SHORT),
		.EE_WAIT_CYCLES(SHORT), .ERASE_WAIT_CYCLES(SHORT)) i_isp_programmer (
		.clock(clock), .rst(rst), .link(link), .session_req(session_req),
		.session_ok(session_ok), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_word(cmd_word), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
	// Second device driven by hand, for misbehaving-programmer cases
	isp_device #(.FLASH_WAIT_CYCLES(LONG), .EE_WAIT_CYCLES(LONG), .ERASE_WAIT_CYCLES(LONG))
		i_isp_device_b (.clock(clock), .rst(rst), .link(link_b), .prog_mode(prog_mode_b),
		.busy(busy_b));
	isp_properties i_isp_properties (.clock(clock), .rst(rst), .sck(link.sck),
		.mosi(link.mosi), .miso(link.miso), .reset_n(link.reset_n));

	// ============================================================
	// Helpers
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task cmd(input logic [31:0] w, input logic [7:0] exp);
		integer n;
		@(negedge clock);
		expq.push_back(exp);
		cmd_word = w;
		cmd_valid = 1'b1;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 2000) begin
			@(negedge clock);
			n++;
		end
		@(negedge clock);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 4000) begin
			@(negedge clock);
			n++;
		end
		check("response wait", {31'h0, rsp_valid}, 32'h1);
	endtask

	task bang(input logic [31:0] w, output logic [31:0] q);
		integer k;
		q = 32'h0;
		for (k = 31; k >= 0; k--) begin
			link_b.mosi = w[k];
			repeat (6) @(negedge clock);
			link_b.sck = 1'b1;
			q = {q[30:0], link_b.miso};
			repeat (6) @(negedge clock);
			link_b.sck = 1'b0;
		end
		repeat (6) @(negedge clock);
	endtask

	// ============================================================
	// Clock, response monitor, watchdog
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	always @(negedge clock) begin
		if (rsp_valid === 1'b1) begin
			if (expq.size() == 0)
				check("spare response", 32'h1, 32'h0);
			else
				check("rsp_data", {24'h0, rsp_data}, {24'h0, expq.pop_front()});
		end
	end

	initial begin
		#4000000;
		n_errors++;
		tally_and_finish();
	end

	// ============================================================
	// Tests
	initial begin
		seed = 36;
		n_errors = 0;
		n_checks = 0;
		rst = 1'b1;
		session_req = 1'b0;
		cmd_valid = 1'b0;
		cmd_word = 32'h0;
		link_b.sck = 1'b0;
		link_b.mosi = 1'b0;
		link_b.reset_n = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		check("idle prog_mode", {31'h0, prog_mode}, 32'h0);
		session_req = 1'b1;
		i = 0;
		while (session_ok !== 1'b1 && i < 5000) begin
			@(negedge clock);
			i++;
		end
		check("prog_mode", {31'h0, prog_mode}, 32'h1);
		check("session_ok", {31'h0, session_ok}, 32'h1);
		$display("test unlock done");
		cmd({UNLOCK_B1, ERASE_B2_TOP, 21'h0}, 8'h00);
		check("erase busy", {31'h0, busy}, 32'h1);
		cmd({OP_READ_EE, 8'h00, 8'h2A, 8'h00}, ERASED_BYTE);
		cmd({OP_READ_FLASH | HIGH_SEL_MASK, 8'h00, 8'hC5, 8'h00}, ERASED_BYTE);
		$display("test erase done");
		for (i = 0; i < 2; i++) begin
			d = 8'($random(seed));
			cmd({OP_WRITE_EE, 8'h00, 8'h15, d}, 8'h15);
			check("ee busy", {31'h0, busy}, 32'h1);
			cmd({OP_READ_EE, 8'h00, 8'h15, 8'h00}, d);
		end
		$display("test eeprom done");
		for (i = 0; i < 4; i++) begin
			lo[i] = 8'($random(seed));
			hi[i] = 8'($random(seed));
			cmd({OP_LOAD_PAGE, 8'h00, 8'(i), lo[i]}, 8'(i));
			cmd({OP_LOAD_PAGE | HIGH_SEL_MASK, 8'h00, 8'(i), hi[i]}, 8'(i));
		end
		cmd({OP_WRITE_PAGE, 8'h00, 8'h80, 8'h00}, 8'h80);
		check("page busy", {31'h0, busy}, 32'h1);
		for (i = 0; i < 4; i++) begin
			cmd({OP_READ_FLASH, 8'h00, 8'h80 | 8'(i), 8'h00}, lo[i]);
			cmd({OP_READ_FLASH | HIGH_SEL_MASK, 8'h00, 8'h80 | 8'(i), 8'h00}, hi[i]);
		end
		cmd({8'h30, 8'h00, 8'h02, 8'h00}, 8'h02);
		$display("test flash done");
		session_req = 1'b0;
		repeat (8) @(negedge clock);
		check("exit prog_mode", {31'h0, prog_mode}, 32'h0);
		$display("test exit done");
		link_b.reset_n = 1'b0;
		repeat (8) @(negedge clock);
		bang({OP_WRITE_EE, 8'h00, 8'h05, 8'h5A}, r);
		check("locked prog_mode", {31'h0, prog_mode_b}, 32'h0);
		bang({UNLOCK_B1, UNLOCK_B2, 16'h0}, r);
		check("echo", {24'h0, r[15:8]}, {24'h0, UNLOCK_B2});
		check("open prog_mode", {31'h0, prog_mode_b}, 32'h1);
		bang({OP_READ_EE, 8'h00, 8'h05, 8'h00}, r);
		check("locked write", {24'h0, r[7:0]}, {24'h0, ERASED_BYTE});
		bang({OP_WRITE_EE, 8'h00, 8'h06, 8'hA5}, r);
		check("busy b", {31'h0, busy_b}, 32'h1);
		bang({OP_READ_EE, 8'h00, 8'h06, 8'h00}, r);
		check("pending ee", {24'h0, r[7:0]}, {24'h0, ERASED_BYTE});
		repeat (LONG) @(negedge clock);
		check("idle busy b", {31'h0, busy_b}, 32'h0);
		bang({OP_READ_EE, 8'h00, 8'h06, 8'h00}, r);
		check("done ee", {24'h0, r[7:0]}, 32'hA5);
		link_b.reset_n = 1'b1;
		repeat (8) @(negedge clock);
		check("exit prog_mode b", {31'h0, prog_mode_b}, 32'h0);
		$display("test hand driven done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
